// ---- logic/seq_pkg.sv ----
// constants for the boost fault and soft-start sequencer
// assumes a 20 MHz system clock and comparator results arriving as pins
//
// Overview of operation
// RULE1: overvoltage stops drive while feedback high
// RULE2: supply lockout releases high, halts low
// RULE3: over-temperature halts all switching
// RULE4: thermal recovery restarts through soft-start
// RULE5: overcurrent ends the present switch-on pulse
// RULE6: eight overcurrent pulses with low feedback: hiccup
// RULE7: hiccup holds off 60ms then soft-starts
// RULE8: reference ramps zero to target over 20ms
// RULE9: soft-start on lockout, thermal, standby, cool-down exit
// RULE10: run input low means standby
// RULE11: open run input reads low, standby
// RULE12: external clock within band, minimum pulse width
// RULE13: synchronised cycles start on external rising edge
// RULE14: changeover delay between free-running and synchronised
// RULE15: drive enable is AND of all permissives
// RULE16: overcurrent counter clears on good pulse, faults
package seq_pkg;
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned HICCUP_LIMIT  = 8;
   localparam int unsigned COOL_MS       = 60;
   localparam int unsigned SS_MS         = 20;
   localparam int unsigned SYNC_DLY_US   = 230;
   localparam int unsigned COOL_CYC      = COOL_MS * (CLK_HZ / 1000);
   localparam int unsigned SS_CYC        = SS_MS * (CLK_HZ / 1000);
   localparam int unsigned SYNC_DLY_CYC  = SYNC_DLY_US * (CLK_HZ / 1_000_000);
   localparam int unsigned REF_W         = 10;
   localparam logic [9:0]  REF_TARGET    = 10'h3ff;
   localparam int unsigned CNT_W         = 22;
   typedef enum logic [3:0] {
      ST_HALT = 4'h1,
      ST_SOFT = 4'h2,
      ST_RUN  = 4'h4,
      ST_COOL = 4'h8
   } state_t;
endpackage

// ---- logic/boost_seq.sv ----
// fault, hiccup, soft-start and oscillator sync sequencer
// assumes comparator outputs and external clock are asynchronous pins
`timescale 1ns/1ns
module boost_seq #(
   parameter int unsigned COOL_CYC_P = seq_pkg::COOL_CYC,
   parameter int unsigned SS_CYC_P   = seq_pkg::SS_CYC
) (
   // clock and reset
   input  wire logic       CLK_SYS,
   input  wire logic       RSTN,
   input  wire logic       CE,
   // comparator inputs
   input  wire logic       OVERVOLTAGE_STOP,
   input  wire logic       SUPPLY_OK,
   input  wire logic       THERMAL_STOP,
   input  wire logic       OVERCURRENT_STOP,
   input  wire logic       FEEDBACK_LOW,
   input  wire logic       RUN_HIGH,
   // oscillator
   input  wire logic       OSC_TICK,
   input  wire logic       SYNC_IN,
   input  wire logic       SYNC_EN,
   // outputs
   output logic            DRIVE_EN,
   output logic            CYCLE_START,
   output logic [9:0]      SS_REF,
   output logic            SOFT_START,
   output logic            HICCUP,
   output logic            SYNC_ACTIVE
);
   ////////////////////////////////////////////////////////////////////////////
   // three-stage pin synchronisers
   localparam int NIN = 8;
   logic [NIN-1:0] pin_raw, s1_r, s2_r, s3_r, flt_r;
   assign pin_raw = {SYNC_EN, SYNC_IN, OSC_TICK, RUN_HIGH, FEEDBACK_LOW,
                     OVERCURRENT_STOP, THERMAL_STOP, OVERVOLTAGE_STOP};
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else if (CE) begin
         s1_r <= pin_raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   // a change counts once stages two and three agree
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         flt_r <= '0;
      end else if (CE) begin
         for (int i = 0; i < NIN; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               flt_r[i] <= s3_r[i];
            end
         end
      end
   end
   logic ov, thermal_stop, oc, fbl, run, tick_lv, sync_lv, sync_req;
   assign {sync_req, sync_lv, tick_lv, run, fbl, oc, thermal_stop, ov} = flt_r;

   // supply lockout synchronised the same way, resets to locked
   logic [2:0] sup_r;
   logic       sup_ok_r;
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         sup_r    <= '0;
         sup_ok_r <= 1'b0;
      end else if (CE) begin
         sup_r <= {sup_r[1:0], SUPPLY_OK};
         if (sup_r[1] == sup_r[2]) begin
            sup_ok_r <= sup_r[2]; // RULE2
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // oscillator source selection with changeover delay
   logic        tick_d_r, sync_d_r, sync_act_r;
   logic [12:0] chg_cnt_r;
   logic        tick_rise, sync_rise, cyc;
   assign tick_rise = tick_lv & ~tick_d_r;
   assign sync_rise = sync_lv & ~sync_d_r;
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         tick_d_r <= 1'b0;
         sync_d_r <= 1'b0;
      end else if (CE) begin
         tick_d_r <= tick_lv;
         sync_d_r <= sync_lv;
      end
   end
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         sync_act_r <= 1'b0;
         chg_cnt_r  <= '0;
      end else if (CE) begin
         if (sync_req == sync_act_r) begin
            chg_cnt_r <= '0;
         end else if (chg_cnt_r == 13'(seq_pkg::SYNC_DLY_CYC - 1)) begin
            sync_act_r <= sync_req; // RULE14
            chg_cnt_r  <= '0;
         end else begin
            chg_cnt_r <= chg_cnt_r + 13'h1;
         end
      end
   end
   // RULE12 is the source's duty; edge detection assumes it
   assign cyc = sync_act_r ? sync_rise : tick_rise; // RULE13

   ////////////////////////////////////////////////////////////////////////////
   // sequencing state machine
   seq_pkg::state_t       st_r, st_nxt;
   logic [seq_pkg::CNT_W-1:0] tmr_r;
   logic [3:0]            oc_cnt_r;
   logic                  oc_seen_r, pulse_on_r;
   logic                  stop_all, ramp_done, cool_done, hic_trip;
   assign stop_all  = ~sup_ok_r | thermal_stop | ~run; // RULE2 RULE3 RULE10 RULE11
   assign ramp_done = (32'(tmr_r) == SS_CYC_P - 1);
   assign cool_done = (32'(tmr_r) == COOL_CYC_P - 1);
   assign hic_trip  = (oc_cnt_r == 4'(seq_pkg::HICCUP_LIMIT));

   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         seq_pkg::ST_HALT: if (!stop_all) st_nxt = seq_pkg::ST_SOFT; // RULE4 RULE9
         seq_pkg::ST_SOFT: begin
            if (stop_all) st_nxt = seq_pkg::ST_HALT;
            else if (hic_trip) st_nxt = seq_pkg::ST_COOL;
            else if (ramp_done) st_nxt = seq_pkg::ST_RUN;
         end
         seq_pkg::ST_RUN: begin
            if (stop_all) st_nxt = seq_pkg::ST_HALT;
            else if (hic_trip) st_nxt = seq_pkg::ST_COOL; // RULE6
         end
         seq_pkg::ST_COOL: begin
            if (stop_all) st_nxt = seq_pkg::ST_HALT;
            else if (cool_done) st_nxt = seq_pkg::ST_SOFT; // RULE7 RULE9
         end
         default: st_nxt = seq_pkg::ST_HALT;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         st_r <= seq_pkg::ST_HALT;
      end else if (CE) begin
         st_r <= st_nxt;
      end
   end

   // shared timer: soft-start ramp and cool-down
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         tmr_r <= '0;
      end else if (CE) begin
         if (st_nxt != st_r || st_r == seq_pkg::ST_HALT || st_r == seq_pkg::ST_RUN) begin
            tmr_r <= '0;
         end else begin
            tmr_r <= tmr_r + 1'b1; // RULE7 RULE8
         end
      end
   end

   // reference ramp, zero to target across the soft-start interval
   logic [9:0]  ref_r;
   logic [31:0] ramp_val;
   assign ramp_val = (32'(tmr_r) * 32'(seq_pkg::REF_TARGET)) / SS_CYC_P;
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         ref_r <= '0;
      end else if (CE) begin
         unique case (st_r)
            seq_pkg::ST_SOFT: ref_r <= ramp_val[9:0]; // RULE8
            seq_pkg::ST_RUN:  ref_r <= seq_pkg::REF_TARGET;
            default: ref_r <= '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-pulse overcurrent and consecutive count
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         pulse_on_r <= 1'b0;
         oc_seen_r  <= 1'b0;
      end else if (CE) begin
         if (cyc) begin
            pulse_on_r <= 1'b1;
            oc_seen_r  <= 1'b0;
         end else if (oc) begin
            pulse_on_r <= 1'b0; // RULE5
            oc_seen_r  <= 1'b1;
         end
      end
   end
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         oc_cnt_r <= '0;
      end else if (CE) begin
         if (stop_all || !fbl || st_r == seq_pkg::ST_COOL) begin
            oc_cnt_r <= '0; // RULE16
         end else if (cyc) begin
            if (!oc_seen_r) oc_cnt_r <= '0; // RULE16
            else if (!hic_trip) oc_cnt_r <= oc_cnt_r + 4'h1; // RULE6
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   logic drv_r, cs_r;
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         drv_r <= 1'b0;
         cs_r  <= 1'b0;
      end else if (CE) begin
         drv_r <= (st_r == seq_pkg::ST_SOFT || st_r == seq_pkg::ST_RUN) && !stop_all
                  && !ov && !oc && !hic_trip && (pulse_on_r || cyc); // RULE1 RULE15
         cs_r  <= cyc;
      end
   end
   assign DRIVE_EN    = drv_r;
   assign CYCLE_START = cs_r;
   assign SS_REF      = ref_r;
   assign SOFT_START  = (st_r == seq_pkg::ST_SOFT);
   assign HICCUP      = (st_r == seq_pkg::ST_COOL);
   assign SYNC_ACTIVE = sync_act_r;
endmodule

// ---- bench/stage_model.sv ----
// far side: switch current sense and external clock source
// assumes the bench clock and a free-running oscillator near 312 kHz
`timescale 1ns/1ns
module stage_model (
   // bench side
   input  wire logic clk,
   input  wire logic drive,
   input  wire logic oc_mode,
   input  wire logic clk_on,
   // design side
   output logic      oc = 1'b0,
   output logic      ext_clk = 1'b0
);
   logic [1:0] on_r = 2'h0;
   logic [5:0] div_r = 6'h0;
   // current reaches the limit three cycles into a pulse
   always @(posedge clk) begin
      on_r <= {on_r[0], drive & oc_mode};
      oc <= on_r[1] & drive;
   end
   // 40-cycle square wave, high 500 ns, still when off
   // faster than the free-running tick so the bench can tell them apart
   always @(posedge clk) begin
      div_r <= (!clk_on || div_r == 6'h27) ? 6'h0 : div_r + 6'h1;
      ext_clk <= clk_on && div_r < 6'ha;
   end
endmodule

// ---- bench/boost_seq_sva.sv ----
// port checker for the sequencer
// assumes clock enable is held high
`timescale 1ns/1ns
module boost_seq_chk (
   input wire logic       CLK_SYS,
   input wire logic       RSTN,
   input wire logic       OVERVOLTAGE_STOP,
   input wire logic       SUPPLY_OK,
   input wire logic       THERMAL_STOP,
   input wire logic       OVERCURRENT_STOP,
   input wire logic       RUN_HIGH,
   input wire logic       SYNC_IN,
   input wire logic       SYNC_EN,
   input wire logic       DRIVE_EN,
   input wire logic       CYCLE_START,
   input wire logic [9:0] SS_REF,
   input wire logic       SOFT_START,
   input wire logic       HICCUP,
   input wire logic       SYNC_ACTIVE
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   chk_ov_stop: assert property (OVERVOLTAGE_STOP[*7] |-> !DRIVE_EN)
      else $error("drive during overvoltage");
   chk_lock_halt: assert property ((!SUPPLY_OK)[*7] |-> !DRIVE_EN && !SOFT_START)
      else $error("run during lockout");
   chk_temp_halt: assert property (THERMAL_STOP[*7] |-> !DRIVE_EN)
      else $error("drive during thermal stop");
   chk_oc_cut: assert property ($rose(OVERCURRENT_STOP) |-> ##[1:7] !DRIVE_EN)
      else $error("pulse not cut");
   chk_standby_off: assert property ((!RUN_HIGH)[*7] |-> !DRIVE_EN && !SOFT_START)
      else $error("run during standby");
   chk_cool_off: assert property (HICCUP |-> !DRIVE_EN && !SOFT_START)
      else $error("drive during cool-down");
   chk_cool_exit: assert property ($fell(HICCUP) && SUPPLY_OK && RUN_HIGH
      && !THERMAL_STOP |-> ##[0:3] SOFT_START)
      else $error("no soft start after cool-down");
   chk_ramp_up: assert property (SOFT_START && $past(SOFT_START)
      |-> SS_REF >= $past(SS_REF))
      else $error("ramp fell");
   chk_sync_wait: assert property ($rose(SYNC_EN) |-> (!SYNC_ACTIVE)[*8])
      else $error("no changeover delay");
   chk_sync_edge: assert property (SYNC_ACTIVE && $rose(SYNC_IN) |-> ##[1:7] CYCLE_START)
      else $error("no cycle on sync edge");
   cover property ($rose(HICCUP));
   cover property ($rose(SYNC_ACTIVE));
   cover property ($fell(SOFT_START));
endmodule
bind boost_seq boost_seq_chk u_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
   .OVERVOLTAGE_STOP(OVERVOLTAGE_STOP), .SUPPLY_OK(SUPPLY_OK), .THERMAL_STOP(THERMAL_STOP),
   .OVERCURRENT_STOP(OVERCURRENT_STOP), .RUN_HIGH(RUN_HIGH), .SYNC_IN(SYNC_IN),
   .SYNC_EN(SYNC_EN), .DRIVE_EN(DRIVE_EN), .CYCLE_START(CYCLE_START), .SS_REF(SS_REF),
   .SOFT_START(SOFT_START), .HICCUP(HICCUP), .SYNC_ACTIVE(SYNC_ACTIVE));

// ---- bench/tb.sv ----
// self-checking bench for the sequencer
// assumes shortened cool-down 50 and ramp 40 cycles
`timescale 1ns/1ns
module tb;
   logic       clk_sys = 1'b0;
   logic       rstn = 1'b0;
   logic [3:0] flt = 4'h0;
   logic       fb_low = 1'b0;
   logic       oc_mode = 1'b0;
   logic       sync_en = 1'b0;
   logic [5:0] osc_r = 6'h0;
   logic       oc, ext_clk, drive_en, cyc, soft_start, hiccup, sync_active;
   logic [9:0] ss_ref;
   int         err_total = 0;
   int         checks_done = 0;
   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) osc_r <= osc_r + 6'h1;
   boost_seq #(.COOL_CYC_P(50), .SS_CYC_P(40)) dut (.CLK_SYS(clk_sys), .RSTN(rstn),
      .CE(1'b1), .OVERVOLTAGE_STOP(flt[0]), .SUPPLY_OK(!flt[1]), .THERMAL_STOP(flt[2]),
      .OVERCURRENT_STOP(oc), .FEEDBACK_LOW(fb_low), .RUN_HIGH(!flt[3]), .OSC_TICK(osc_r[5]),
      .SYNC_IN(ext_clk), .SYNC_EN(sync_en), .DRIVE_EN(drive_en), .CYCLE_START(cyc),
      .SS_REF(ss_ref), .SOFT_START(soft_start), .HICCUP(hiccup), .SYNC_ACTIVE(sync_active));
   stage_model far (.clk(clk_sys), .drive(drive_en), .oc_mode(oc_mode), .clk_on(sync_en),
      .oc(oc), .ext_clk(ext_clk));
   ////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic hold(input string what, ref logic s, input logic v, input int lim);
      int n;
      n = 0;
      while (s !== v && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
      chk(what, {31'h0, v}, {31'h0, s});
   endtask
   task automatic count_hi(input string what, ref logic s, input int n, input int exp);
      int c;
      c = 0;
      repeat (n) begin
         @(negedge clk_sys);
         c += int'(s === 1'b1);
      end
      chk(what, exp, c);
   endtask
   task automatic results;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      results();
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      hold("soft_start", soft_start, 1'b1, 20);
      hold("ramp_end", soft_start, 1'b0, 60);
      @(negedge clk_sys);
      chk("ss_ref", {22'h0, seq_pkg::REF_TARGET}, {22'h0, ss_ref});
      hold("drive", drive_en, 1'b1, 200);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         flt <= 4'h1 << i;
         repeat (10) @(negedge clk_sys);
         count_hi("drive_stop", drive_en, 130, 0);
         @(posedge clk_sys);
         flt <= 4'h0;
         if (i > 0) begin
            hold("restart", soft_start, 1'b1, 20);
            hold("ramp_end", soft_start, 1'b0, 60);
         end
         hold("resume", drive_en, 1'b1, 200);
      end
      @(posedge clk_sys);
      fb_low <= 1'b1;
      oc_mode <= 1'b1;
      repeat (320) @(posedge clk_sys);
      oc_mode <= 1'b0;
      repeat (130) @(posedge clk_sys);
      oc_mode <= 1'b1;
      count_hi("no_trip", hiccup, 320, 0);
      hold("hiccup", hiccup, 1'b1, 700);
      @(posedge clk_sys);
      oc_mode <= 1'b0;
      count_hi("cool", drive_en, 50, 0);
      hold("cool_end", hiccup, 1'b0, 20);
      hold("restart", soft_start, 1'b1, 5);
      @(posedge clk_sys);
      fb_low <= 1'b0;
      hold("ramp_end", soft_start, 1'b0, 60);
      @(posedge clk_sys);
      sync_en <= 1'b1;
      count_hi("sync_wait", sync_active, 4000, 0);
      hold("sync_active", sync_active, 1'b1, 1000);
      count_hi("sync_cycles", cyc, 640, 16);
      results();
   end
endmodule
